// File: core/tocu_top.sv
// Timer output compare unit: 16-bit counter, two compare channels,
// match and overflow flags, and the APB register slave.
// Assumes a prescaler tick and the capture value on the same clock.
//
// Behaviour
// - Each channel compares count with its value; match flags next tick.
// - Enabled set flag raises a request; servicing it clears the flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - Channel A value can set the counter TOP in modes selecting it.
// - Compare value is buffered in PWM modes, not in normal or CTC.
// - Buffered value moves to active only at TOP or BOTTOM.
// - CPU writes buffer when buffered else active; hardware never alters.
// - Compare reads return both bytes directly, not via the latch.
// - High byte goes to the latch; low write moves both in one cycle.
// - Force strobe in non-PWM modes acts as match, no flag, no reload.
// - Counter write blocks matches of the next timer tick.
// - Compare output state is kept across waveform mode changes.
// - Output action is unbuffered and applies from the next match.
// - Compare output state clears to zero at reset.
// - Nonzero action overrides port value; direction bit still rules.
// - Output action has no effect on input capture.
// - Action zero leaves the compare output unchanged on match.
// - Mode sets counting; action picks polarity or set, clear, toggle.
// - Normal mode always counts up and wraps from MAX to zero.
// - Normal mode sets overflow as counter becomes zero; only sets.
// - Normal mode accepts counter writes at any time.
// - Clock source zero stops counting; counter stays accessible.
// - CPU counter write wins over clear or count.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
module tocu_top
  import tocu_pkg::*;
(
  input  wire logic              clk_sys,     // System clock, 25 MHz
  input  wire logic              arst_n,      // Async reset, low
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB enable
  input  wire logic              pwrite,      // APB direction
  input  wire logic [ADDR_W-1:0] paddr,       // APB byte address
  input  wire logic [31:0]       pwdata,      // APB write data
  output logic [31:0]            prdata,      // APB read data
  output logic                   pready,      // APB ready
  output logic                   pslverr,     // APB error
  input  wire logic              tmr_tick,    // Prescaler tick
  input  wire logic [CNT_W-1:0]  capture_value, // TOP in ICR modes
  input  wire logic [2:0]        irq_ack,     // Request serviced
  output logic [2:0]             irq_req,     // Requests A, B, ovf
  output logic [1:0]             pin_o,       // Pin level A, B
  output logic [1:0]             pin_oe_n     // Pin drive, low
);

  typedef struct packed {
    logic [3:0]       wgm;
    logic [2:0]       cs;
    logic [1:0]       act_a;
    logic [1:0]       act_b;
    logic [2:0]       ien;
    logic [2:0]       flags;
    logic [CNT_W-1:0] count;
    logic [7:0]       temp;
    logic             block;
    logic             down;
    logic [1:0]       port_val;
    logic [1:0]       dir;
    logic [1:0]       pin_o;
    logic [1:0]       pin_oe_n;
    logic [2:0]       irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } tocu_top_st_t;

  tocu_top_st_t   st_q, st_d;
  tocu_cnt_info_t info;
  tocu_mode_t     mode;
  logic [CNT_W-1:0] top;
  logic [CNT_W-1:0] cmp_a, cmp_b, buf_a, buf_b;
  logic           hit_a, hit_b, out_a, out_b;
  logic           tick, wr_done, rd_prep;
  logic           wr_cnt, wr_cmpa, wr_cmpb;
  logic [1:0]     force_stb;
  logic [CNT_W-1:0] wr16;
  logic [7:0]     wbyte;

  function automatic tocu_mode_t mode_of(input logic [3:0] w);
    case (w)
      4'h0, 4'hD:                 mode_of = MD_NORMAL;
      4'h4, 4'hC:                 mode_of = MD_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_of = MD_FAST;
      4'h8, 4'h9:                 mode_of = MD_PFC;
      default:                    mode_of = MD_PC;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] top_of(
    input logic [3:0]       w,
    input logic [CNT_W-1:0] ocr_a,
    input logic [CNT_W-1:0] icr
  );
    case (w)
      4'h1, 4'h5:                 top_of = TOP_8B;
      4'h2, 4'h6:                 top_of = TOP_9B;
      4'h3, 4'h7:                 top_of = TOP_10B;
      4'h4, 4'h9, 4'hB, 4'hF:     top_of = ocr_a;
      4'h8, 4'hA, 4'hC, 4'hE:     top_of = icr;
      default:                    top_of = CNT_MAX;
    endcase
  endfunction

  function automatic logic [7:0] sel_byte(
    input logic [CNT_W-1:0] v,
    input logic             hi
  );
    sel_byte = hi ? v[15:8] : v[7:0];
  endfunction

  always_comb begin
    mode = mode_of(st_q.wgm);
    top  = top_of(st_q.wgm, cmp_a, capture_value);
    // Stopped clock source means no timer ticks at all
    tick = tmr_tick && (st_q.cs != CS_RST);
    wbyte = pwdata[7:0];
    wr16  = {st_q.temp, wbyte};
    // Write side effects take place at the completing edge, read side effects one edge earlier
    wr_done = psel && penable && st_q.pready && pwrite;
    rd_prep = psel && penable && !st_q.pready && !pwrite;
    wr_cnt  = wr_done && (paddr == OFS_CNT_LO);
    wr_cmpa = wr_done && (paddr == OFS_CMPA_LO);
    wr_cmpb = wr_done && (paddr == OFS_CMPB_LO);
    force_stb[0] = wr_done && (paddr == OFS_FORCE) && pwdata[0];
    force_stb[1] = wr_done && (paddr == OFS_FORCE) && pwdata[1];

    info.hit_en = tick && !st_q.block;
    info.pwm    = (mode == MD_FAST) || (mode == MD_PC) ||
                  (mode == MD_PFC);
    info.fast   = (mode == MD_FAST);
    info.dual   = (mode == MD_PC) || (mode == MD_PFC);
    info.down   = st_q.down;
    info.bottom = tick && info.fast && (st_q.count == top);
    case (mode)
      MD_FAST: info.reload = tick && (st_q.count == top);
      MD_PC:   info.reload = tick && (st_q.count == top);
      MD_PFC:  info.reload = tick && (st_q.count == CNT_RST);
      default: info.reload = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;

    // Flag clears come before every set so that a same-cycle event wins
    if (wr_done && paddr == OFS_FLAGS) begin
      st_d.flags = st_d.flags & ~pwdata[2:0];
    end
    st_d.flags = st_d.flags & ~irq_ack;

    // Counting sequence follows the mode alone
    if (tick) begin
      case (mode)
        MD_NORMAL: begin
          st_d.count = st_q.count + 16'h0001;
          if (st_q.count == CNT_MAX) st_d.flags[BIT_OVF] = 1'b1;
        end
        MD_CTC: begin
          if (st_q.count == top) st_d.count = CNT_RST;
          else st_d.count = st_q.count + 16'h0001;
          if (st_q.count == CNT_MAX) st_d.flags[BIT_OVF] = 1'b1;
        end
        MD_FAST: begin
          // Equality only: a count above TOP runs on through MAX
          if (st_q.count == top) begin
            st_d.count = CNT_RST;
            st_d.flags[BIT_OVF] = 1'b1;
          end else begin
            st_d.count = st_q.count + 16'h0001;
          end
        end
        default: begin
          if (!st_q.down) begin
            if (st_q.count == top) begin
              st_d.down  = 1'b1;
              st_d.count = st_q.count - 16'h0001;
            end else begin
              st_d.count = st_q.count + 16'h0001;
            end
          end else if (st_q.count == CNT_RST) begin
            st_d.down  = 1'b0;
            st_d.count = st_q.count + 16'h0001;
            st_d.flags[BIT_OVF] = 1'b1;
          end else begin
            st_d.count = st_q.count - 16'h0001;
          end
        end
      endcase
    end
    if (!info.dual) st_d.down = 1'b0;

    // A counter write blocks matches until the next tick has passed
    if (tick) st_d.block = 1'b0;
    if (wr_cnt) begin
      st_d.count = wr16;
      st_d.block = 1'b1;
    end

    if (hit_a) st_d.flags[BIT_CMPA] = 1'b1;
    if (hit_b) st_d.flags[BIT_CMPB] = 1'b1;
    if (tick && mode == MD_NORMAL && st_q.count == CNT_MAX) begin
      st_d.flags[BIT_OVF] = 1'b1;
    end

    // Plain register writes
    if (wr_done) begin
      case (paddr)
        OFS_CTRL: begin
          // Mode change leaves the channel output states alone
          st_d.wgm   = pwdata[CTRL_WGM_LSB +: 4];
          st_d.cs    = pwdata[CTRL_CS_LSB +: 3];
          st_d.act_a = pwdata[CTRL_ACTA_LSB +: 2];
          st_d.act_b = pwdata[CTRL_ACTB_LSB +: 2];
        end
        OFS_IRQ_EN: st_d.ien = pwdata[2:0];
        OFS_CNT_HI, OFS_CMPA_HI, OFS_CMPB_HI: begin
          st_d.temp = wbyte;
        end
        OFS_PORT: begin
          st_d.port_val = pwdata[PORT_VAL_LSB +: 2];
          st_d.dir      = pwdata[PORT_DIR_LSB +: 2];
        end
        default: st_d.temp = st_q.temp;
      endcase
    end

    // APB: one wait state, answer registered
    st_d.pready  = psel && penable && !st_q.pready;
    st_d.pslverr = 1'b0;
    if (psel && penable && !st_q.pready) begin
      case (paddr)
        OFS_CTRL, OFS_IRQ_EN, OFS_FLAGS, OFS_FORCE, OFS_CNT_LO,
        OFS_CNT_HI, OFS_CMPA_LO, OFS_CMPA_HI, OFS_CMPB_LO,
        OFS_CMPB_HI, OFS_PORT: st_d.pslverr = 1'b0;
        default:               st_d.pslverr = 1'b1;
      endcase
    end
    if (rd_prep) begin
      st_d.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CTRL: begin
          st_d.prdata[CTRL_WGM_LSB +: 4]  = st_q.wgm;
          st_d.prdata[CTRL_CS_LSB +: 3]   = st_q.cs;
          st_d.prdata[CTRL_ACTA_LSB +: 2] = st_q.act_a;
          st_d.prdata[CTRL_ACTB_LSB +: 2] = st_q.act_b;
        end
        OFS_IRQ_EN: st_d.prdata[2:0] = st_q.ien;
        OFS_FLAGS:  st_d.prdata[2:0] = st_q.flags;
        OFS_CNT_LO: begin
          // Low read snapshots the high byte for a coherent pair
          st_d.prdata[7:0] = sel_byte(st_q.count, 1'b0);
          st_d.temp        = sel_byte(st_q.count, 1'b1);
        end
        OFS_CNT_HI:  st_d.prdata[7:0] = st_q.temp;
        OFS_CMPA_LO: st_d.prdata[7:0] =
                       sel_byte(info.pwm ? buf_a : cmp_a, 1'b0);
        OFS_CMPA_HI: st_d.prdata[7:0] =
                       sel_byte(info.pwm ? buf_a : cmp_a, 1'b1);
        OFS_CMPB_LO: st_d.prdata[7:0] =
                       sel_byte(info.pwm ? buf_b : cmp_b, 1'b0);
        OFS_CMPB_HI: st_d.prdata[7:0] =
                       sel_byte(info.pwm ? buf_b : cmp_b, 1'b1);
        OFS_PORT: begin
          st_d.prdata[PORT_VAL_LSB +: 2] = st_q.port_val;
          st_d.prdata[PORT_DIR_LSB +: 2] = st_q.dir;
          st_d.prdata[5:4]               = {out_b, out_a};
        end
        default: st_d.prdata = 32'h0000_0000;
      endcase
    end

    // Requests follow flags gated by their enables
    st_d.irq = st_q.flags & st_q.ien;

    // Any nonzero action hands the pin value to the compare output;
    // the direction bit alone decides whether the pin is driven
    st_d.pin_o[0] = (st_q.act_a != ACT_NONE) ? out_a
                                             : st_q.port_val[0];
    st_d.pin_o[1] = (st_q.act_b != ACT_NONE) ? out_b
                                             : st_q.port_val[1];
    st_d.pin_oe_n = ~st_q.dir;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q          <= '0;
      st_q.wgm      <= WGM_RST;
      st_q.cs       <= CS_RST;
      st_q.count    <= CNT_RST;
      st_q.pin_oe_n <= 2'h3;
    end else begin
      st_q <= st_d;
    end
  end

  tocu_channel u_chan_a (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .cnt       (st_q.count),
    .info      (info),
    .action    (st_q.act_a),
    .force_stb (force_stb[0]),
    .wr_en     (wr_cmpa),
    .wr_data   (wr16),
    .hit       (hit_a),
    .cmp_act   (cmp_a),
    .cmp_buf   (buf_a),
    .out_st    (out_a)
  );

  tocu_channel u_chan_b (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .cnt       (st_q.count),
    .info      (info),
    .action    (st_q.act_b),
    .force_stb (force_stb[1]),
    .wr_en     (wr_cmpb),
    .wr_data   (wr16),
    .hit       (hit_b),
    .cmp_act   (cmp_b),
    .cmp_buf   (buf_b),
    .out_st    (out_b)
  );

  // The input capture unit is outside; no action bit reaches it
  assign prdata   = st_q.prdata;
  assign pready   = st_q.pready;
  assign pslverr  = st_q.pslverr;
  assign irq_req  = st_q.irq;
  assign pin_o    = st_q.pin_o;
  assign pin_oe_n = st_q.pin_oe_n;

endmodule

// File: inc/tocu_pkg.sv
// Shared constants and types of the timer output compare unit.
// Assumes a 32-bit APB register bus and one system clock.
package tocu_pkg;

  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FORCE   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMPA_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMPA_HI = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CMPB_LO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CMPB_HI = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PORT    = 8'h28;

  // CTRL field positions
  localparam int unsigned CTRL_WGM_LSB  = 0;
  localparam int unsigned CTRL_CS_LSB   = 4;
  localparam int unsigned CTRL_ACTA_LSB = 8;
  localparam int unsigned CTRL_ACTB_LSB = 10;
  // Flag / enable bit positions
  localparam int unsigned BIT_CMPA = 0;
  localparam int unsigned BIT_CMPB = 1;
  localparam int unsigned BIT_OVF  = 2;
  // PORT field positions
  localparam int unsigned PORT_VAL_LSB = 0;
  localparam int unsigned PORT_DIR_LSB = 2;

  // Reset values and fixed counter limits
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] TOP_8B   = 16'h00FF;
  localparam logic [CNT_W-1:0] TOP_9B   = 16'h01FF;
  localparam logic [CNT_W-1:0] TOP_10B  = 16'h03FF;
  localparam logic [3:0]       WGM_RST  = 4'h0;
  localparam logic [2:0]       CS_RST   = 3'h0;
  localparam logic [1:0]       ACT_NONE = 2'h0;
  localparam logic [1:0]       ACT_TGL  = 2'h1;
  localparam logic [1:0]       ACT_CLR  = 2'h2;
  localparam logic [1:0]       ACT_SET  = 2'h3;

  typedef enum {MD_NORMAL, MD_CTC, MD_FAST, MD_PC, MD_PFC} tocu_mode_t;

  // What the counter tells each compare channel in one cycle
  typedef struct packed {
    logic       hit_en;   // Timer tick with matches not blocked
    logic       pwm;      // Buffering active
    logic       fast;     // Single-slope PWM
    logic       dual;     // Dual-slope PWM
    logic       down;     // Counting down (dual slope)
    logic       reload;   // Load active value from buffer now
    logic       bottom;   // Fast PWM restart from bottom now
  } tocu_cnt_info_t;

  typedef struct packed {
    logic [CNT_W-1:0] cmp_act;
    logic [CNT_W-1:0] cmp_buf;
    logic             out_st;
  } tocu_chan_st_t;

endpackage

// File: core/tocu_channel.sv
// One compare channel: active and buffered compare value, match
// detection and the internal compare output state.
// Assumes the counter unit supplies tick, mode and reload timing.
module tocu_channel
  import tocu_pkg::*;
(
  input  wire logic             clk_sys,    // System clock
  input  wire logic             arst_n,     // Async reset, low
  input  wire logic [CNT_W-1:0] cnt,        // Current count
  input  tocu_cnt_info_t        info,       // Counter timing info
  input  wire logic [1:0]       action,     // Output action select
  input  wire logic             force_stb,  // Force compare strobe
  input  wire logic             wr_en,      // Compare value write
  input  wire logic [CNT_W-1:0] wr_data,    // Value written
  output logic                  hit,        // Real match this tick
  output logic [CNT_W-1:0]      cmp_act,    // Active compare value
  output logic [CNT_W-1:0]      cmp_buf,    // Buffered value
  output logic                  out_st      // Compare output state
);

  tocu_chan_st_t st_q, st_d;
  logic          act_ev;
  logic          nxt;

  always_comb begin
    st_d = st_q;
    hit  = info.hit_en && (cnt == st_q.cmp_act);
    act_ev = hit || (force_stb && !info.pwm);
    nxt = st_q.out_st;
    if (info.pwm) begin
      // Inverted or non-inverted waveform only
      if (info.fast) begin
        if (hit && action == ACT_CLR) nxt = 1'b0;
        if (hit && action == ACT_SET) nxt = 1'b1;
        if (info.bottom && action == ACT_CLR) nxt = 1'b1;
        if (info.bottom && action == ACT_SET) nxt = 1'b0;
      end else if (hit) begin
        if (action == ACT_CLR) nxt = info.down;
        if (action == ACT_SET) nxt = !info.down;
      end
    end else if (act_ev) begin
      case (action)
        ACT_TGL: nxt = !st_q.out_st;
        ACT_CLR: nxt = 1'b0;
        ACT_SET: nxt = 1'b1;
        default: nxt = st_q.out_st;
      endcase
    end
    // Action is read live, so a new setting hits the next match
    st_d.out_st = nxt;
    if (info.pwm && info.reload) st_d.cmp_act = st_q.cmp_buf;
    if (wr_en) begin
      if (info.pwm) st_d.cmp_buf = wr_data;
      else st_d.cmp_act = wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{cmp_act: CNT_RST, cmp_buf: CNT_RST, out_st: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cmp_act = st_q.cmp_act;
  assign cmp_buf = st_q.cmp_buf;
  assign out_st  = st_q.out_st;

endmodule

// File: tb/tocu_properties.sv
// Port-level checks of the timer output compare unit.
// Assumes it is bound to tocu_top and sees only that module's ports.
module tocu_properties
  import tocu_pkg::*;
(
  input wire logic       clk_sys,  // System clock
  input wire logic       arst_n,   // Async reset, low
  input wire logic       psel,     // APB select
  input wire logic       penable,  // APB enable
  input wire logic       pwrite,   // APB direction
  input wire logic       pready,   // APB ready
  input wire logic       pslverr,  // APB error
  input wire logic       tmr_tick, // Prescaler tick
  input wire logic [2:0] irq_ack,  // Request serviced
  input wire logic [2:0] irq_req,  // Requests
  input wire logic [1:0] pin_o,    // Pin levels
  input wire logic [1:0] pin_oe_n  // Pin drive, low
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic wr;
  assign wr = psel && penable && pready && pwrite;

  AST_APB_WAIT:
    assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("pready not in second access cycle");
  AST_APB_PULSE:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_APB_CAUSE:
    assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside an access phase");
  AST_ERR_READY:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_MATCH_CAUSE:
    assert property ($rose(irq_req[0]) |-> $past(tmr_tick, 2) || $past(wr, 2))
    else $error("compare request without tick or write");
  AST_OVF_CAUSE:
    assert property ($rose(irq_req[2]) |-> $past(tmr_tick, 2) || $past(wr, 2))
    else $error("overflow request without tick or write");
  AST_ACK_CLEARS:
    assert property (irq_ack[2] && !tmr_tick |-> ##2 !irq_req[2])
    else $error("overflow request survives service");
  AST_PIN_CAUSE:
    assert property (!$stable(pin_o) |-> $past(tmr_tick, 2) || $past(wr, 2))
    else $error("pin level moved without cause");
  AST_OE_CAUSE:
    assert property (!$stable(pin_oe_n) |-> $past(wr) || $past(wr, 2))
    else $error("pin drive moved without a write");
endmodule

// File: tb/tocu_top_tb.sv
// Self-checking bench of the timer output compare unit.
// Assumes tocu_top with its APB slave and the tocu_pkg offsets.
module tocu_top_tb
  import tocu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              tmr_tick = 1'b0;
  logic [2:0]        irq_ack = 3'h0;
  logic [2:0]        irq_req;
  logic [1:0]        pin_o;
  logic [1:0]        pin_oe_n;
  logic [31:0]       rd;
  logic              se;
  int                err_count = 0;
  int                checks_done = 0;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

  always #20 clk_sys = ~clk_sys;

  tocu_top i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr_tick(tmr_tick),
    .capture_value(16'h0000), .irq_ack(irq_ack), .irq_req(irq_req),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n));

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 10);
    if (n >= 10) err_count++;
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // High byte first: the low write moves the latch in with it
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    apb(1'b1, lo + 8'h04, {24'h0, v[15:8]});
    apb(1'b1, lo, {24'h0, v[7:0]});
  endtask

  task automatic tick(input int n);
    @(posedge clk_sys);
    tmr_tick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    tmr_tick <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    `CHK("pin_o", 2'b00, pin_o)
    `CHK("pin_oe_n", 2'b11, pin_oe_n)
    apb(1'b0, OFS_PORT, 0);
    `CHK("port", 32'h0, rd)
    apb(1'b0, 8'h3C, 0);
    `CHK("unmapped err", 1'b1, se)
    `CHK("unmapped data", 32'h0, rd)
    $display("reset test done");
  endtask

  task automatic t_match;
    wr16(OFS_CMPA_LO, 16'h0105);
    apb(1'b0, OFS_CMPA_LO, 0);
    `CHK("cmp lo", 8'h05, rd[7:0])
    apb(1'b0, OFS_CMPA_HI, 0);
    `CHK("cmp hi", 8'h01, rd[7:0])
    wr16(OFS_CNT_LO, 16'h0100);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h110);
    tick(10);
    apb(1'b0, OFS_FLAGS, 0);
    `CHK("flag a", 1'b1, rd[0])
    `CHK("irq a", 1'b1, irq_req[0])
    apb(1'b0, OFS_PORT, 0);
    `CHK("toggle", 1'b1, rd[4])
    apb(1'b1, OFS_FLAGS, 32'h0);
    apb(1'b0, OFS_FLAGS, 0);
    `CHK("flag keep", 1'b1, rd[0])
    apb(1'b1, OFS_FLAGS, 32'h1);
    apb(1'b0, OFS_FLAGS, 0);
    `CHK("flag clr", 1'b0, rd[0])
    $display("match test done");
  endtask

  task automatic t_block;
    apb(1'b1, OFS_CTRL, 32'h100);
    wr16(OFS_CNT_LO, 16'h0105);
    tick(3);
    apb(1'b0, OFS_CNT_LO, 0);
    `CHK("stopped", 8'h05, rd[7:0])
    apb(1'b1, OFS_CTRL, 32'h110);
    tick(2);
    apb(1'b0, OFS_FLAGS, 0);
    `CHK("blocked", 1'b0, rd[0])
    $display("block test done");
  endtask

  task automatic t_force;
    logic [1:0] act [4] = '{ACT_CLR, ACT_SET, ACT_NONE, ACT_TGL};
    logic       exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_CTRL, {22'h0, act[i], 8'h00});
      apb(1'b1, OFS_FORCE, 32'h1);
      apb(1'b0, OFS_PORT, 0);
      `CHK("forced state", exp[i], rd[4])
      apb(1'b0, OFS_FLAGS, 0);
      `CHK("force flag", 1'b0, rd[0])
    end
    $display("force test done");
  endtask

  task automatic t_pin;
    apb(1'b1, OFS_PORT, 32'h6);
    apb(1'b1, OFS_CTRL, 32'h100);
    apb(1'b1, OFS_FORCE, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h105);
    apb(1'b0, OFS_PORT, 0);
    `CHK("port rd", 6'h16, rd[5:0])
    `CHK("pin ovr", 1'b1, pin_o[0])
    `CHK("pin oe", 2'b10, pin_oe_n)
    `CHK("pin b gpio", 1'b1, pin_o[1])
    apb(1'b1, OFS_CTRL, 32'h005);
    repeat (2) @(posedge clk_sys);
    `CHK("pin gpio", 1'b0, pin_o[0])
    $display("pin test done");
  endtask

  task automatic t_ovf;
    apb(1'b1, OFS_CTRL, 32'h010);
    apb(1'b1, OFS_IRQ_EN, 32'h4);
    wr16(OFS_CNT_LO, 16'hFFFE);
    tick(4);
    apb(1'b0, OFS_CNT_LO, 0);
    `CHK("wrap lo", 8'h02, rd[7:0])
    apb(1'b0, OFS_CNT_HI, 0);
    `CHK("wrap hi", 8'h00, rd[7:0])
    apb(1'b0, OFS_FLAGS, 0);
    `CHK("ovf flag", 1'b1, rd[2])
    `CHK("ovf irq", 1'b1, irq_req[2])
    `CHK("flag b", 1'b1, rd[1])
    `CHK("irq b", 1'b0, irq_req[1])
    @(posedge clk_sys);
    irq_ack <= 3'h4;
    @(posedge clk_sys);
    irq_ack <= 3'h0;
    repeat (3) @(posedge clk_sys);
    `CHK("ovf serviced", 1'b0, irq_req[2])
    $display("overflow test done");
  endtask

  // Fast PWM with TOP 0xFF: the new value waits in the buffer until TOP
  task automatic t_buffer;
    apb(1'b1, OFS_CTRL, 32'h015);
    wr16(OFS_CNT_LO, 16'h00F0);
    wr16(OFS_CMPA_LO, 16'h00F2);
    apb(1'b0, OFS_CMPA_LO, 0);
    `CHK("buf read", 8'hF2, rd[7:0])
    apb(1'b1, OFS_FLAGS, 32'h7);
    tick(8);
    apb(1'b0, OFS_FLAGS, 0);
    `CHK("buffered", 1'b0, rd[0])
    tick(8);
    wr16(OFS_CNT_LO, 16'h00F0);
    tick(4);
    apb(1'b0, OFS_FLAGS, 0);
    `CHK("reloaded", 1'b1, rd[0])
    `CHK("top ovf", 1'b1, rd[2])
    $display("buffer test done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_match();
    t_block();
    t_force();
    t_pin();
    t_ovf();
    t_buffer();
    final_report();
  end

  // Whole run is a few hundred cycles; this cuts a hung handshake
  initial begin
    #200000;
    err_count++;
    final_report();
  end
endmodule

bind tocu_top tocu_properties i_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .tmr_tick(tmr_tick), .irq_ack(irq_ack), .irq_req(irq_req),
  .pin_o(pin_o), .pin_oe_n(pin_oe_n));
